// ===== src/sbp_consts.vh
// Purpose: shared constants for the serial block packetizer
// Assumes: 100 MHz mclk, byte-wide serial and network streams
// Notes: register offsets are word indices on the plain register port
`ifndef SBP_CONSTS_VH
`define SBP_CONSTS_VH

// ---------------------------------------------------------------
// timing
// ---------------------------------------------------------------
`define SBP_CLK_KHZ 100000
`define SBP_TICK_MS 10

// ---------------------------------------------------------------
// buffers
// ---------------------------------------------------------------
`define SBP_AW 8
`define SBP_PW 9
`define SBP_DEPTH 256

// ---------------------------------------------------------------
// register indices
// ---------------------------------------------------------------
`define SBP_REG_CTRL 4'h0
`define SBP_REG_START 4'h1
`define SBP_REG_STOP 4'h2
`define SBP_REG_TRAIL 4'h3
`define SBP_REG_GAP 4'h4
`define SBP_REG_LEN 4'h5
`define SBP_REG_STAT 4'h6
`define SBP_REG_S2N_LVL 4'h7
`define SBP_REG_S2N_CMT 4'h8
`define SBP_REG_N2S_LVL 4'h9

// ctrl field positions
`define SBP_CTRL_ANY 0
`define SBP_CTRL_START_EN 1
`define SBP_CTRL_STOP_EN 2

// ---------------------------------------------------------------
// reset values
// ---------------------------------------------------------------
`define SBP_RST_CTRL 8'h01
`define SBP_RST_CODE 8'h00
`define SBP_RST_TRAIL 8'h00
`define SBP_RST_GAP 8'h01
`define SBP_RST_LEN_UDP 8'hff
`define SBP_RST_LEN_TCP 8'h7f

`endif

// ===== src/sbp_packetizer.v
// Purpose: serial block framer between a serial byte stream and a network packet engine
// Assumes: all inputs synchronous to mclk; one received byte per rx_valid pulse
// Notes: both buffers hold 256 bytes; a serial byte arriving at a full buffer is lost, network bytes are refused
//
// The register offsets and the strobed register port were chosen for this implementation.
`include "sbp_consts.vh"
`default_nettype none

module sbp_packetizer #(
    parameter TICK_CYCLES = `SBP_TICK_MS * `SBP_CLK_KHZ
) (
    // clock and reset
    input wire mclk,
    input wire reset,
    // register port
    input wire [3:0] reg_addr,
    input wire [7:0] reg_wdata,
    input wire reg_wr,
    input wire reg_rd,
    output reg [7:0] reg_rdata,
    // link state
    input wire conn_open,
    input wire port_open,
    input wire transport_tcp,
    // serial receive side
    input wire rx_valid,
    input wire [7:0] rx_data,
    // serial transmit side
    output reg tx_valid,
    output reg [7:0] tx_data,
    input wire tx_ready,
    // network packets in
    input wire net_in_valid,
    input wire [7:0] net_in_data,
    output wire net_in_ready,
    // network data out
    output reg net_out_valid,
    output reg [7:0] net_out_data,
    input wire net_out_ready
);

    // ---------------------------------------------------------------
    // helpers and states
    // ---------------------------------------------------------------
    localparam ST_IDLE = 2'b00;
    localparam ST_OPEN = 2'b01;
    localparam ST_TRAIL = 2'b10;

    // bytes between two wrapping pointers
    function [`SBP_PW-1:0] sbp_level;
        input [`SBP_PW-1:0] hi;
        input [`SBP_PW-1:0] lo;
        begin
            sbp_level = hi - lo;
        end
    endfunction

    // ---------------------------------------------------------------
    // settings registers
    // ---------------------------------------------------------------
    reg [7:0] ctrl_r;
    reg [7:0] start_byte_code_r;
    reg [7:0] stop_byte_code_r;
    reg [7:0] trailing_byte_count_r;
    reg [7:0] max_gap_delay_r;
    reg [7:0] max_block_length_r;

    wire open_on_any_byte = ctrl_r[`SBP_CTRL_ANY];
    wire start_byte_enable = ctrl_r[`SBP_CTRL_START_EN];
    wire stop_byte_enable = ctrl_r[`SBP_CTRL_STOP_EN];

    // synchronous reset, so the transport strap is caught at reset time
    always @(posedge mclk) begin
        if (reset) begin
            ctrl_r <= `SBP_RST_CTRL;
            start_byte_code_r <= `SBP_RST_CODE;
            stop_byte_code_r <= `SBP_RST_CODE;
            trailing_byte_count_r <= `SBP_RST_TRAIL;
            max_gap_delay_r <= `SBP_RST_GAP;
            max_block_length_r <= transport_tcp ? `SBP_RST_LEN_TCP : `SBP_RST_LEN_UDP;
        end else if (reg_wr) begin
            if (reg_addr == `SBP_REG_CTRL) begin
                ctrl_r <= {5'h00, reg_wdata[2:0]};
            end else if (reg_addr == `SBP_REG_START) begin
                start_byte_code_r <= reg_wdata;
            end else if (reg_addr == `SBP_REG_STOP) begin
                stop_byte_code_r <= reg_wdata;
            end else if (reg_addr == `SBP_REG_TRAIL) begin
                trailing_byte_count_r <= reg_wdata;
            end else if (reg_addr == `SBP_REG_GAP) begin
                max_gap_delay_r <= reg_wdata;
            end else if (reg_addr == `SBP_REG_LEN) begin
                max_block_length_r <= reg_wdata;
            end
        end
    end

    // ---------------------------------------------------------------
    // serial-to-network buffer and framing
    // ---------------------------------------------------------------
    reg [7:0] s2n_mem [0:`SBP_DEPTH-1];
    reg [`SBP_PW-1:0] s2n_wr_r;
    reg [`SBP_PW-1:0] s2n_rd_r;
    reg [`SBP_PW-1:0] s2n_cmt_r;
    reg [1:0] state_r;
    reg [1:0] state_nxt;
    reg [7:0] trail_left_r;
    reg [7:0] trail_left_nxt;
    reg store;
    reg commit;

    wire [`SBP_PW-1:0] s2n_lvl = sbp_level(s2n_wr_r, s2n_rd_r);
    wire [`SBP_PW-1:0] s2n_cmt_lvl = sbp_level(s2n_cmt_r, s2n_rd_r);
    wire s2n_full = s2n_lvl[`SBP_PW-1];
    wire rx_take = rx_valid && port_open && conn_open;
    wire is_stop = stop_byte_enable && (rx_data == stop_byte_code_r);
    wire [`SBP_PW-1:0] s2n_wr_nxt = (store && !s2n_full) ? s2n_wr_r + 1'b1 : s2n_wr_r;
    wire gap_break;
    wire len_break = (state_r != ST_IDLE) && (s2n_lvl > {1'b0, max_block_length_r});

    // framing decisions per received byte
    always @* begin
        state_nxt = state_r;
        trail_left_nxt = trail_left_r;
        store = 1'b0;
        commit = gap_break || len_break;
        case (state_r)
            ST_IDLE: begin
                // bytes between blocks are dropped unless they open one
                if (rx_take && (open_on_any_byte || (start_byte_enable && rx_data == start_byte_code_r))) begin
                    state_nxt = ST_OPEN;
                    store = 1'b1;
                end
            end
            ST_OPEN: begin
                if (rx_take) begin
                    store = 1'b1;
                    if (is_stop) begin
                        if (trailing_byte_count_r == 8'h00) begin
                            state_nxt = ST_IDLE;
                            commit = 1'b1;
                        end else begin
                            state_nxt = ST_TRAIL;
                            trail_left_nxt = trailing_byte_count_r;
                        end
                    end
                end
            end
            ST_TRAIL: begin
                if (rx_take) begin
                    store = 1'b1;
                    trail_left_nxt = trail_left_r - 8'h01;
                    if (trail_left_r == 8'h01) begin
                        state_nxt = ST_IDLE;
                        commit = 1'b1;
                    end
                end
            end
            default: begin
                state_nxt = ST_IDLE;
            end
        endcase
    end

    // framing state; a closed connection ends any block
    always @(posedge mclk) begin
        if (reset || !conn_open) begin
            state_r <= ST_IDLE;
            trail_left_r <= 8'h00;
        end else begin
            state_r <= state_nxt;
            trail_left_r <= trail_left_nxt;
        end
    end

    // buffer pointers; the commit point takes in a byte stored the same cycle
    always @(posedge mclk) begin
        if (reset || !conn_open) begin
            s2n_wr_r <= {`SBP_PW{1'b0}};
            s2n_cmt_r <= {`SBP_PW{1'b0}};
        end else begin
            s2n_wr_r <= s2n_wr_nxt;
            if (commit) begin
                s2n_cmt_r <= s2n_wr_nxt;
            end
        end
    end

    // storage write
    always @(posedge mclk) begin
        if (store && !s2n_full) begin
            s2n_mem[s2n_wr_r[`SBP_AW-1:0]] <= rx_data;
        end
    end

    // ---------------------------------------------------------------
    // inter-byte gap timer
    // ---------------------------------------------------------------
    reg [31:0] tick_cnt_r;
    reg [8:0] gap_ticks_r;
    wire timing = (state_r != ST_IDLE);
    wire tick = (tick_cnt_r == TICK_CYCLES - 1);

    // fires once per silence; the tick count stops climbing after it
    assign gap_break = timing && tick && (gap_ticks_r == {1'b0, max_gap_delay_r});

    always @(posedge mclk) begin
        if (reset || !timing || rx_take) begin
            tick_cnt_r <= 32'h0000_0000;
            gap_ticks_r <= 9'h000;
        end else begin
            tick_cnt_r <= tick ? 32'h0000_0000 : tick_cnt_r + 32'h0000_0001;
            if (tick && gap_ticks_r <= {1'b0, max_gap_delay_r}) begin
                gap_ticks_r <= gap_ticks_r + 9'h001;
            end
        end
    end

    // ---------------------------------------------------------------
    // committed data toward the network
    // ---------------------------------------------------------------
    wire s2n_pop = (s2n_cmt_lvl != {`SBP_PW{1'b0}}) && (!net_out_valid || net_out_ready);

    // one-byte output stage keeps the data lines on flip-flops
    always @(posedge mclk) begin
        if (reset || !conn_open) begin
            s2n_rd_r <= {`SBP_PW{1'b0}};
            net_out_valid <= 1'b0;
            net_out_data <= 8'h00;
        end else begin
            if (s2n_pop) begin
                s2n_rd_r <= s2n_rd_r + 1'b1;
                net_out_valid <= 1'b1;
                net_out_data <= s2n_mem[s2n_rd_r[`SBP_AW-1:0]];
            end else if (net_out_ready) begin
                net_out_valid <= 1'b0;
            end
        end
    end

    // ---------------------------------------------------------------
    // network-to-serial buffer
    // ---------------------------------------------------------------
    reg [7:0] n2s_mem [0:`SBP_DEPTH-1];
    reg [`SBP_PW-1:0] n2s_wr_r;
    reg [`SBP_PW-1:0] n2s_rd_r;
    wire [`SBP_PW-1:0] n2s_lvl = sbp_level(n2s_wr_r, n2s_rd_r);

    // back-pressure: refuse network bytes while full or unconnected
    assign net_in_ready = conn_open && !n2s_lvl[`SBP_PW-1];
    wire n2s_push = net_in_valid && net_in_ready;
    wire n2s_pop = (n2s_lvl != {`SBP_PW{1'b0}}) && (!tx_valid || tx_ready);

    always @(posedge mclk) begin
        if (n2s_push) begin
            n2s_mem[n2s_wr_r[`SBP_AW-1:0]] <= net_in_data;
        end
    end

    // bytes leave in arrival order, content untouched
    always @(posedge mclk) begin
        if (reset || !conn_open) begin
            n2s_wr_r <= {`SBP_PW{1'b0}};
            n2s_rd_r <= {`SBP_PW{1'b0}};
            tx_valid <= 1'b0;
            tx_data <= 8'h00;
        end else begin
            if (n2s_push) begin
                n2s_wr_r <= n2s_wr_r + 1'b1;
            end
            if (n2s_pop) begin
                n2s_rd_r <= n2s_rd_r + 1'b1;
                tx_valid <= 1'b1;
                tx_data <= n2s_mem[n2s_rd_r[`SBP_AW-1:0]];
            end else if (tx_ready) begin
                tx_valid <= 1'b0;
            end
        end
    end

    // ---------------------------------------------------------------
    // register read port, data one cycle after the strobe
    // ---------------------------------------------------------------
    always @(posedge mclk) begin
        if (reset) begin
            reg_rdata <= 8'h00;
        end else if (reg_rd) begin
            if (reg_addr == `SBP_REG_CTRL) begin
                reg_rdata <= ctrl_r;
            end else if (reg_addr == `SBP_REG_START) begin
                reg_rdata <= start_byte_code_r;
            end else if (reg_addr == `SBP_REG_STOP) begin
                reg_rdata <= stop_byte_code_r;
            end else if (reg_addr == `SBP_REG_TRAIL) begin
                reg_rdata <= trailing_byte_count_r;
            end else if (reg_addr == `SBP_REG_GAP) begin
                reg_rdata <= max_gap_delay_r;
            end else if (reg_addr == `SBP_REG_LEN) begin
                reg_rdata <= max_block_length_r;
            end else if (reg_addr == `SBP_REG_STAT) begin
                reg_rdata <= {s2n_full, n2s_lvl[`SBP_PW-1], 4'h0, state_r};
            end else if (reg_addr == `SBP_REG_S2N_LVL) begin
                reg_rdata <= s2n_full ? 8'hff : s2n_lvl[7:0];
            end else if (reg_addr == `SBP_REG_S2N_CMT) begin
                reg_rdata <= s2n_cmt_lvl[`SBP_PW-1] ? 8'hff : s2n_cmt_lvl[7:0];
            end else if (reg_addr == `SBP_REG_N2S_LVL) begin
                reg_rdata <= n2s_lvl[`SBP_PW-1] ? 8'hff : n2s_lvl[7:0];
            end else begin
                reg_rdata <= 8'h00; // unmapped reads as zero
            end
        end
    end

endmodule

`default_nettype wire

// ===== testbench/sbp_far.sv
// Purpose: far-end model: network engine sink and serial transmitter
// Assumes: ready changes only just after a rising edge
// Notes: slow paces both readies to every other cycle; stall holds them low
`default_nettype none
module sbp_far (
    // clock and reset
    input wire logic mclk,
    input wire logic reset,
    // pacing
    input wire logic stall,
    input wire logic slow,
    // network data out of the block
    input wire logic net_out_valid,
    input wire logic [7:0] net_out_data,
    output var logic net_out_ready,
    // serial transmit side
    input wire logic tx_valid,
    input wire logic [7:0] tx_data,
    output var logic tx_ready
);
    timeunit 1ns;
    timeprecision 100ps;
    logic [7:0] net_q[$];
    logic [7:0] tx_q[$];
    logic phase_r = 1'b0;
    // record every byte taken, in arrival order
    always @(posedge mclk) begin
        if (!reset && net_out_valid && net_out_ready)
            net_q.push_back(net_out_data);
        if (!reset && tx_valid && tx_ready)
            tx_q.push_back(tx_data);
        phase_r <= reset ? 1'b0 : ~phase_r;
        net_out_ready <= !reset && !stall && (!slow || phase_r);
        tx_ready <= !reset && !stall && (!slow || phase_r);
    end
endmodule
`default_nettype wire

// ===== testbench/sbp_packetizer_bench.sv
// Purpose: self-checking bench for the serial block packetizer
// Assumes: tick shortened to 8 mclk cycles, udp strap
// Notes: the far-end queues are emptied by each connection close
`include "sbp_consts.vh"
`default_nettype none
module sbp_packetizer_bench;
    timeunit 1ns;
    timeprecision 100ps;
    logic mclk = 1'b0;
    logic reset = 1'b1;
    logic [3:0] reg_addr = 4'h0;
    logic [7:0] reg_wdata = 8'h00;
    logic reg_wr = 1'b0;
    logic reg_rd = 1'b0;
    logic conn_open = 1'b1;
    logic port_open = 1'b1;
    // strap is driven so a second reset can check the tcp length default
    logic transport_tcp = 1'b0;
    logic rx_valid = 1'b0;
    logic [7:0] rx_data = 8'h00;
    logic net_in_valid = 1'b0;
    logic [7:0] net_in_data = 8'h00;
    logic stall = 1'b0;
    logic slow = 1'b0;
    wire logic [7:0] reg_rdata, tx_data, net_out_data;
    wire logic tx_valid, tx_ready, net_in_ready, net_out_valid, net_out_ready;
    int num_errors = 0;
    int num_checks = 0;
    always #5 mclk = ~mclk;
    sbp_packetizer #(.TICK_CYCLES(8)) sbp_packetizer_i (.mclk, .reset, .reg_addr, .reg_wdata, .reg_wr,
        .reg_rd, .reg_rdata, .conn_open, .port_open, .transport_tcp, .rx_valid, .rx_data, .tx_valid,
        .tx_data, .tx_ready, .net_in_valid, .net_in_data, .net_in_ready, .net_out_valid, .net_out_data,
        .net_out_ready);
    sbp_far sbp_far_i (.mclk, .reset, .stall, .slow, .net_out_valid, .net_out_data, .net_out_ready,
        .tx_valid, .tx_data, .tx_ready);
    // ---------------------------------------------------------------
    // access tasks
    // ---------------------------------------------------------------
    task automatic close_out();
        $display("checks %0d mismatches %0d", num_checks, num_errors);
        if (num_errors == 0 && num_checks > 0)
            $display("NO MISMATCHES");
        else
            $display("MISMATCHES SEEN");
        $finish;
    endtask
    task automatic chk(input string name, input logic [7:0] seen, input logic [7:0] exp);
        num_checks++;
        if (seen !== exp) begin
            num_errors++;
            $display("unexpected %s: expected %h seen %h", name, exp, seen);
        end
    endtask
    task automatic fail_wait();
        num_errors++;
        $display("unexpected wait length: bound used up");
        close_out();
    endtask
    task automatic wr(input logic [3:0] a, input logic [7:0] d);
        @(posedge mclk);
        reg_addr <= a;
        reg_wdata <= d;
        reg_wr <= 1'b1;
        @(posedge mclk);
        reg_wr <= 1'b0;
    endtask
    // read data is looked at only in the cycle after the strobe
    task automatic rd(input logic [3:0] a, input string name, input logic [7:0] exp);
        @(posedge mclk);
        reg_addr <= a;
        reg_rd <= 1'b1;
        @(posedge mclk);
        reg_rd <= 1'b0;
        #1 chk(name, reg_rdata, exp);
    endtask
    task automatic rx(input logic [7:0] b);
        @(posedge mclk);
        rx_valid <= 1'b1;
        rx_data <= b;
        @(posedge mclk);
        rx_valid <= 1'b0;
    endtask
    // ready is looked at before the edge, so the push lands on a known edge
    task automatic push(input logic [7:0] b);
        int n = 0;
        @(posedge mclk);
        net_in_valid <= 1'b1;
        net_in_data <= b;
        @(negedge mclk);
        while (net_in_ready !== 1'b1 && n < 50) begin
            @(negedge mclk);
            n++;
        end
        if (net_in_ready !== 1'b1)
            fail_wait();
        @(posedge mclk);
        net_in_valid <= 1'b0;
    endtask
    task automatic none_yet();
        repeat (4) @(posedge mclk);
        chk("net count", 8'(sbp_far_i.net_q.size()), 8'h00);
        chk("tx count", 8'(sbp_far_i.tx_q.size()), 8'h00);
    endtask
    task automatic expect_out(input bit on_tx, input logic [7:0] e[$]);
        int n = 0;
        while ((on_tx ? sbp_far_i.tx_q.size() : sbp_far_i.net_q.size()) < e.size() && n < 400) begin
            @(posedge mclk);
            n++;
        end
        if ((on_tx ? sbp_far_i.tx_q.size() : sbp_far_i.net_q.size()) < e.size())
            fail_wait();
        foreach (e[i])
            chk("out byte", on_tx ? sbp_far_i.tx_q[i] : sbp_far_i.net_q[i], e[i]);
    endtask
    // a connection close ends the block but keeps settings
    task automatic clean();
        @(posedge mclk);
        conn_open <= 1'b0;
        repeat (2) @(posedge mclk);
        conn_open <= 1'b1;
        sbp_far_i.net_q.delete();
        sbp_far_i.tx_q.delete();
    endtask
    // ---------------------------------------------------------------
    // tests
    // ---------------------------------------------------------------
    initial begin
        repeat (8) @(posedge mclk);
        reset <= 1'b0;
        rd(`SBP_REG_CTRL, "ctrl", 8'h01);
        rd(`SBP_REG_GAP, "gap", 8'h01);
        rd(`SBP_REG_LEN, "len", 8'hff);
        rd(`SBP_REG_STOP, "stop", 8'h00);
        rd(4'hf, "unmapped", 8'h00);
        $display("test defaults done");
        rx(8'h41);
        rx(8'h42);
        rd(`SBP_REG_S2N_LVL, "s2n level", 8'h02);
        rd(`SBP_REG_S2N_CMT, "s2n committed", 8'h00);
        chk("net count", 8'(sbp_far_i.net_q.size()), 8'h00);
        expect_out(1'b0, {8'h41, 8'h42});
        stall <= 1'b1;
        rx(8'h43);
        rd(`SBP_REG_S2N_LVL, "s2n level", 8'h01);
        port_open <= 1'b0;
        rx(8'h50);
        port_open <= 1'b1;
        rd(`SBP_REG_S2N_LVL, "s2n level", 8'h01);
        push(8'h61);
        push(8'h62);
        clean();
        rd(`SBP_REG_S2N_LVL, "s2n level", 8'h00);
        rd(`SBP_REG_N2S_LVL, "n2s level", 8'h00);
        stall <= 1'b0;
        none_yet();
        $display("test gap and close done");
        wr(`SBP_REG_CTRL, 8'h02);
        wr(`SBP_REG_START, 8'h55);
        wr(`SBP_REG_GAP, 8'hff);
        rx(8'h11);
        rx(8'h55);
        rx(8'h55);
        rx(8'h22);
        rd(`SBP_REG_S2N_LVL, "s2n level", 8'h03);
        wr(`SBP_REG_CTRL, 8'h06);
        wr(`SBP_REG_STOP, 8'haa);
        wr(`SBP_REG_TRAIL, 8'h02);
        rx(8'haa);
        rx(8'h44);
        rd(`SBP_REG_STAT, "status", 8'h02);
        none_yet();
        rx(8'h45);
        expect_out(1'b0, {8'h55, 8'h55, 8'h22, 8'haa, 8'h44, 8'h45});
        rx(8'h77);
        rx(8'h55);
        rd(`SBP_REG_S2N_LVL, "s2n level", 8'h01);
        clean();
        $display("test start and stop done");
        // paced sink from here on, so offered network bytes must wait
        slow <= 1'b1;
        wr(`SBP_REG_CTRL, 8'h01);
        rx(8'haa);
        rx(8'h10);
        rd(`SBP_REG_S2N_LVL, "s2n level", 8'h02);
        wr(`SBP_REG_LEN, 8'h03);
        rx(8'h11);
        none_yet();
        rx(8'h12);
        expect_out(1'b0, {8'haa, 8'h10, 8'h11, 8'h12});
        clean();
        $display("test length done");
        push(8'h31);
        push(8'h32);
        push(8'h33);
        expect_out(1'b1, {8'h31, 8'h32, 8'h33});
        $display("test serial out done");
        // second reset with the tcp strap: settings fall back to defaults
        transport_tcp <= 1'b1;
        reset <= 1'b1;
        repeat (2) @(posedge mclk);
        reset <= 1'b0;
        rd(`SBP_REG_LEN, "len tcp", 8'h7f);
        rd(`SBP_REG_GAP, "gap", 8'h01);
        $display("test tcp defaults done");
        close_out();
    end
endmodule
`default_nettype wire

// ===== testbench/sbp_packetizer_properties.sv
// Purpose: port-level properties of the serial block packetizer
// Assumes: one mclk domain, synchronous active-high reset
// Notes: buffer levels are not visible here, so checks tie outputs to link state
`default_nettype none
module sbp_packetizer_props (
    // clock and reset
    input wire logic mclk,
    input wire logic reset,
    // link state
    input wire logic conn_open,
    // serial transmit side
    input wire logic tx_valid,
    input wire logic [7:0] tx_data,
    input wire logic tx_ready,
    // network side
    input wire logic net_in_ready,
    input wire logic net_out_valid,
    input wire logic [7:0] net_out_data,
    input wire logic net_out_ready
);
    timeunit 1ns;
    timeprecision 100ps;
    default clocking @(posedge mclk);
    endclocking
    default disable iff (reset);
    // ---------------------------------------------------------------
    // closing the connection empties both directions
    // ---------------------------------------------------------------
    AST_READY_CONN: assert property (!conn_open |-> !net_in_ready)
        else $error("net_in_ready high while connection closed");
    AST_CLEAR_NET: assert property (!conn_open |=> !net_out_valid)
        else $error("net_out_valid survived a connection close");
    AST_CLEAR_TX: assert property (!conn_open [*2] |-> !tx_valid)
        else $error("tx_valid survived a connection close");
    // an emptied buffer must take a byte as soon as the link reopens
    AST_REOPEN_READY: assert property ($rose(conn_open) |-> net_in_ready)
        else $error("net_in_ready low right after reopen");
    // ---------------------------------------------------------------
    // offered bytes stand until taken, so none are lost or reordered
    // ---------------------------------------------------------------
    AST_HOLD_NET: assert property ((net_out_valid && !net_out_ready && conn_open) ##1 conn_open
        |-> net_out_valid && $stable(net_out_data))
        else $error("net_out byte changed before it was taken");
    AST_HOLD_TX: assert property ((tx_valid && !tx_ready && conn_open)
        |=> !conn_open || (tx_valid && tx_data == $past(tx_data)))
        else $error("tx byte changed before it was taken");
    AST_NET_CONN: assert property ($rose(net_out_valid) |-> $past(conn_open))
        else $error("net_out_valid rose with connection closed");
    AST_TX_CONN: assert property ($rose(tx_valid) |-> $past(conn_open))
        else $error("tx_valid rose with connection closed");
    // main traffic shapes
    COV_NET_TAKE: cover property (net_out_valid && net_out_ready);
    COV_NET_STALL: cover property (net_out_valid && !net_out_ready ##1 net_out_valid);
    COV_TX_TAKE: cover property (tx_valid && tx_ready);
endmodule
bind sbp_packetizer sbp_packetizer_props sbp_packetizer_props_i (.mclk, .reset, .conn_open, .tx_valid,
    .tx_data, .tx_ready, .net_in_ready, .net_out_valid, .net_out_data, .net_out_ready);
`default_nettype wire
